// *** rtl/pixel_readout_defines.svh ***
// Constants for the pixel array readout addressing block.
// Assumes core_clk at 100 MHz; included by its bare name.
`ifndef PIXEL_READOUT_DEFINES_SVH
`define PIXEL_READOUT_DEFINES_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_PS 10000
`define BLANK_TIME_NS 7200
`define BLANK_CYCLES ((`BLANK_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PIXEL_PERIOD_PS 25000
`define PIXEL_CYCLES ((`PIXEL_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define WINDOW_GRAIN 24
`define COL_ORIGIN_MAX 7'h62
`define ROW_ORIGIN_MAX 8'h89
`define ACTIVE_EXTRA 2

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define COL_SKIP_LSB 2
`define ROW_SKIP_LSB 5
`define BOTH_SIDE_BIT 4
`define SKIP_DEFAULT 3'h0

`endif

// *** rtl/pixel_readout_pkg.sv ***
// Types for the pixel array readout addressing block.
// Used by the top module and the testbench.
package pixel_readout_pkg;
    typedef logic [2:0] skip_code_t;
    typedef logic [11:0] row_addr_t;
    typedef logic [11:0] col_addr_t;
    typedef enum logic [1:0] {
        MODE_DOUBLE_SAMPLE,
        MODE_NONDESTRUCTIVE
    } read_mode_t;
endpackage : pixel_readout_pkg

// *** rtl/skip_step_if.sv ***
// Carrier between the readout core and the step decoder.
// One code in, one step size out.
`timescale 1ns/10ps
interface skip_step_if;
    logic [2:0] code;
    logic [3:0] step;
    modport core (output code, input step);
    modport decoder (input code, output step);
endinterface : skip_step_if

// *** rtl/skip_step_decoder.sv ***
// Decodes a three-bit skip code into a pixel step.
// Purely combinational; one instance per direction.
`timescale 1ns/10ps
module skip_step_decoder (
    skip_step_if.decoder port_a
);
    function automatic logic [3:0] stepOf(input logic [2:0] c);
        logic [3:0] s;
        s = 4'hc;
        if (c[2] == 1'b0) begin
            s = {c[1:0], 1'b0} + 4'h2;
        end
        return s;
    endfunction : stepOf

    assign port_a.step = stepOf(port_a.code);
endmodule : skip_step_decoder

// *** rtl/pixel_readout_addressing.sv ***
// Readout addressing of the pixel array: window, skip, rolling shutter.
// Assumes frame start and row advance are one-cycle pulses on core_clk.
`timescale 1ns/10ps
`include "pixel_readout_defines.svh"

// What this block does
// - Row time is blanking interval plus one pixel period per pixel pair.
// - Row origin loads on frame start, column origin on row advance.
// - Window origins are in units of 24 pixels.
// - Every pattern reads a pair of adjacent pixels, then skips.
// - Skip patterns repeat inside 24 pixel blocks.
// - Column origin has 99 choices, row origin 138.
// - Active count is a multiple of 24 plus two.
// - Odd and even columns are addressed together.
// - Rows are addressed one at a time with row skip.
// - Skip code gives step 2, 4, 6, 8 or 12.
// - Separate readout and reset row pointers.
// - Both pointers move on one row advance; offset sets integration.
// - Both-side or nondestructive variants 1 and 2 drive both sides.
// - Dual slope: long slope spans frame, short uses shutter time.
// - Double sampling unless nondestructive readout is selected.
// - Nondestructive reads without reset after the first one.
// - Column skip in bits 4:2, row skip in 7:5.
// - Column origin 0 to 98, row origin 0 to 137.
// - Sequencer bit 4 selects both-side addressing.
module pixel_readout_addressing
    import pixel_readout_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic frameStart,
    input wire logic rowAdvance,
    input wire logic [7:0] arrayControl,
    input wire logic [11:0] sequencerControl,
    input wire logic [6:0] colOrigin,
    input wire logic [7:0] rowOrigin,
    input wire logic [11:0] rowCount,
    input wire logic [10:0] pairCount,
    input wire logic [11:0] shutterRows,
    output logic [11:0] readRow,
    output logic [11:0] resetRow,
    output logic rowSelect,
    output logic resetPulse,
    output logic bothSides,
    output logic [11:0] oddColumn,
    output logic [11:0] evenColumn,
    output logic pixelValid,
    output logic rowBlanking,
    output logic doubleSample,
    output logic frameDone,
    output logic [11:0] longSlopeRows,
    output logic [11:0] shortSlopeRows
);
    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam int unsigned BLANK_CYC = `BLANK_CYCLES;
    localparam int unsigned PIX_CYC = `PIXEL_CYCLES;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // skip field positions
    wire skip_code_t colSkip = arrayControl[`COL_SKIP_LSB +: 3];
    wire skip_code_t rowSkip = arrayControl[`ROW_SKIP_LSB +: 3];
    wire logic nondestructiveOn = sequencerControl[0];
    wire logic [1:0] nondestructiveVariant = sequencerControl[2:1];
    wire logic bothSideSel = sequencerControl[`BOTH_SIDE_BIT];
    wire logic sharedVariant = nondestructiveVariant == 2'h1 | nondestructiveVariant == 2'h2;

    skip_step_if colStepBus ();
    skip_step_if rowStepBus ();
    assign colStepBus.code = colSkip;
    assign rowStepBus.code = rowSkip;
    skip_step_decoder colDecoder (.port_a(colStepBus));
    skip_step_decoder rowDecoder (.port_a(rowStepBus));

    // Origins above range clamp, so the pointer never leaves the array
    function automatic logic [11:0] originToAddr(input logic [7:0] o, input logic [7:0] lim);
        logic [7:0] c;
        c = (o > lim) ? lim : o;
        return 12'(c * `WINDOW_GRAIN);
    endfunction : originToAddr

    // origin ranges of 99 and 138
    wire logic [11:0] colBase = originToAddr({1'b0, colOrigin}, {1'b0, `COL_ORIGIN_MAX});
    wire logic [11:0] rowBase = originToAddr(rowOrigin, `ROW_ORIGIN_MAX);
    // window span is grain multiple plus the extra pair
    wire logic [11:0] extraPix = 12'(`ACTIVE_EXTRA);
    // Last origin plus the extra pair; anything wider runs into dummy columns
    wire logic [11:0] arrayEdge = 12'(`COL_ORIGIN_MAX * `WINDOW_GRAIN) + extraPix;

    // ------------------------------------------------------------
    // Row state
    // ------------------------------------------------------------
    logic [11:0] rowsLeft;
    logic rowPhase;
    logic [11:0] next_readRow;
    logic [11:0] next_resetRow;
    wire logic rowsActive = rowsLeft != 12'h000;
    // row pairs, then skip by step
    assign next_readRow = rowPhase ? readRow + 12'(rowStepBus.step) - 12'h001
                                   : readRow + 12'h001;
    assign next_resetRow = next_readRow + shutterRows;

    // ------------------------------------------------------------
    // Column sweep
    // ------------------------------------------------------------
    logic [11:0] blankCount;
    logic [11:0] pixCount;
    logic [10:0] pairsLeft;
    wire logic blankEnd = blankCount == 12'h001;
    wire logic pixTick = pixCount == 12'(PIX_CYC - 1);
    wire logic lastPair = pairsLeft == 11'h001;

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    // combined side drive
    wire logic next_bothSides = bothSideSel | (nondestructiveOn & sharedVariant);
    wire logic next_doubleSample = ~nondestructiveOn;
    // long slope spans the readout, short is the shutter
    wire logic [11:0] next_longSlope = rowCount;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            readRow <= 12'h000;
            resetRow <= 12'h000;
            rowsLeft <= 12'h000;
            rowPhase <= 1'b0;
            rowSelect <= 1'b0;
            resetPulse <= 1'b0;
            frameDone <= 1'b0;
        end else if (frameStart) begin
            readRow <= rowBase;
            resetRow <= rowBase + shutterRows;
            rowsLeft <= rowCount;
            rowPhase <= 1'b0;
            rowSelect <= 1'b0;
            resetPulse <= 1'b0;
            frameDone <= 1'b0;
        end else if (rowAdvance && rowsActive) begin
            readRow <= (rowSelect) ? next_readRow : readRow;
            resetRow <= (rowSelect) ? next_resetRow : resetRow;
            rowPhase <= rowSelect ? ~rowPhase : 1'b0;
            rowsLeft <= rowsLeft - 12'h001;
            rowSelect <= 1'b1;
            // nondestructive resets only in the first pass
            resetPulse <= ~nondestructiveOn | (rowsLeft == rowCount);
            frameDone <= 1'b0;
        end else if (rowAdvance) begin
            // pointer holds until next frame start
            rowSelect <= 1'b0;
            resetPulse <= 1'b0;
            frameDone <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            blankCount <= 12'h000;
            pixCount <= 12'h000;
            pairsLeft <= 11'h000;
            oddColumn <= 12'h000;
            evenColumn <= 12'h000;
            pixelValid <= 1'b0;
            rowBlanking <= 1'b0;
        end else if (rowAdvance && rowsActive) begin
            blankCount <= 12'(BLANK_CYC);
            pixCount <= 12'h000;
            pairsLeft <= pairCount;
            oddColumn <= colBase + 12'h001;
            evenColumn <= colBase;
            pixelValid <= 1'b0;
            rowBlanking <= 1'b1;
        end else if (blankCount != 12'h000) begin
            blankCount <= blankCount - 12'h001;
            if (blankEnd) begin
                rowBlanking <= 1'b0;
                pixelValid <= pairsLeft != 11'h000;
            end
        end else if (pixelValid) begin
            pixCount <= pixTick ? 12'h000 : pixCount + 12'h001;
            if (pixTick) begin
                evenColumn <= evenColumn + 12'(colStepBus.step);
                oddColumn <= oddColumn + 12'(colStepBus.step);
                pairsLeft <= pairsLeft - 11'h001;
                pixelValid <= ~lastPair;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bothSides <= 1'b0;
            doubleSample <= 1'b1;
            longSlopeRows <= 12'h000;
            shortSlopeRows <= 12'h000;
        end else begin
            bothSides <= next_bothSides;
            doubleSample <= next_doubleSample;
            longSlopeRows <= next_longSlope;
            shortSlopeRows <= shutterRows;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_row_preset: assert property (@(posedge core_clk) disable iff (!rst_b)
        frameStart |=> readRow == $past(rowBase)) else $error("row origin not loaded");
    chk_col_preset: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart) |=> evenColumn == $past(colBase))
        else $error("column origin not loaded");
    chk_pair_cols: assert property (@(posedge core_clk) disable iff (!rst_b)
        pixelValid |-> oddColumn == evenColumn + 12'h001) else $error("columns split");
    chk_shutter_offset: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart) |=> resetRow == readRow + $past(shutterRows))
        else $error("pointer offset wrong");
    chk_blank_time: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart) |=> rowBlanking [*8])
        else $error("blanking too short");
    chk_row_halt: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!rowsActive && !frameStart) |=> $stable(readRow)) else $error("pointer moved");
    chk_double_samp: assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 doubleSample == !$past(nondestructiveOn)) else $error("sampling mode wrong");
    chk_both_side: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(bothSideSel) |-> bothSides) else $error("both sides off");
    chk_step_code: assert property (@(posedge core_clk) disable iff (!rst_b)
        colSkip[2] |-> colStepBus.step == 4'hc) else $error("step wrong");

    chk_row_select: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart) |=> rowSelect)
        else $error("row not selected");

    chk_row_pair: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart && rowSelect && !rowPhase)
        |=> readRow == $past(readRow) + 12'h001)
        else $error("row pair broken");

    chk_row_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart && rowSelect && rowPhase)
        |=> readRow == $past(readRow) + 12'($past(rowStepBus.step)) - 12'h001)
        else $error("row step wrong");

    chk_col_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pixelValid && pixTick && blankCount == 12'h000 && !(rowAdvance && rowsActive))
        |=> evenColumn == $past(evenColumn) + 12'($past(colStepBus.step)))
        else $error("column step wrong");

    // Steps that do not divide the block would shift window edges per pattern
    chk_step_grain: assert property (@(posedge core_clk) disable iff (!rst_b)
        8'(`WINDOW_GRAIN) % 8'(rowStepBus.step) == 8'h00
        && 8'(`WINDOW_GRAIN) % 8'(colStepBus.step) == 8'h00)
        else $error("step does not divide block");

    chk_blank_end: assert property (@(posedge core_clk) disable iff (!rst_b)
        (blankEnd && !(rowAdvance && rowsActive)) |=> !rowBlanking)
        else $error("blanking overrun");

    chk_single_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && rowsActive && !frameStart && nondestructiveOn && rowsLeft != rowCount)
        |=> !resetPulse)
        else $error("extra nondestructive reset");

    chk_frame_done: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rowAdvance && !rowsActive && !frameStart) |=> frameDone && !rowSelect)
        else $error("overrun not refused");

    chk_done_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        frameStart |=> !frameDone)
        else $error("done not cleared");

    chk_slope_copy: assert property (@(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> longSlopeRows == $past(rowCount) && shortSlopeRows == $past(shutterRows))
        else $error("slope rows wrong");

    chk_origin_clamp: assert property (@(posedge core_clk) disable iff (!rst_b)
        colBase <= 12'(`COL_ORIGIN_MAX * `WINDOW_GRAIN)
        && rowBase <= 12'(`ROW_ORIGIN_MAX * `WINDOW_GRAIN))
        else $error("origin past range");

    chk_origin_grain: assert property (@(posedge core_clk) disable iff (!rst_b)
        colBase % 12'(`WINDOW_GRAIN) == 12'h000
        && rowBase % 12'(`WINDOW_GRAIN) == 12'h000)
        else $error("origin off grain");

    chk_window_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
        colBase + extraPix <= arrayEdge)
        else $error("window edge past array");

    chk_skip_split: assert property (@(posedge core_clk) disable iff (!rst_b)
        (colSkip[2] != rowSkip[2]) |-> colStepBus.step != rowStepBus.step)
        else $error("skip codes coupled");
endmodule : pixel_readout_addressing

// *** testbench/camera_controller_model.sv ***
// Model of the external camera controller: frame start and row advance.
// Assumes core_clk from the bench; pulses change on the falling edge.
`timescale 1ns/10ps
module camera_controller_model (
    input wire logic core_clk,
    input wire logic startReq,
    input wire logic [11:0] nRows,
    input wire logic [15:0] gap,
    output logic frameStart,
    output logic rowAdvance,
    output logic busy
);
    // ------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------
    initial begin
        frameStart = 1'b0;
        rowAdvance = 1'b0;
        busy = 1'b0;
        forever begin
            @(negedge core_clk);
            if (startReq === 1'b1) begin
                busy = 1'b1;
                frameStart = 1'b1;
                @(negedge core_clk);
                frameStart = 1'b0;
                repeat (3) @(negedge core_clk);
                // One advance past the row count, so the refusal is exercised
                for (int r = 0; r <= nRows; r++) begin
                    rowAdvance = 1'b1;
                    @(negedge core_clk);
                    rowAdvance = 1'b0;
                    repeat (gap) @(negedge core_clk);
                end
                busy = 1'b0;
            end
        end
    end
endmodule : camera_controller_model

// *** testbench/pixel_readout_addressing_tb.sv ***
// Self-checking bench for the readout addressing block.
// Assumes the controller model drives frame and row pulses.
`timescale 1ns/10ps
module pixel_readout_addressing_tb
    import pixel_readout_pkg::*;
;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic startReq = 1'b0;
    logic [7:0] arrayControl = 8'h00;
    logic [11:0] sequencerControl = 12'h000;
    logic [6:0] colOrigin = 7'h00;
    logic [7:0] rowOrigin = 8'h00;
    logic [11:0] rowCount = 12'h001;
    logic [10:0] pairCount = 11'h001;
    logic [11:0] shutterRows = 12'h000;
    logic frameStart, rowAdvance, busy, rowSelect, bothSides, pixelValid;
    logic rowBlanking, doubleSample, frameDone, resetPulse;
    logic [11:0] readRow, resetRow, oddColumn, evenColumn, longSlopeRows, shortSlopeRows;
    logic [11:0] colBase, expRow;
    int n_fail = 0;
    int n_checks = 0;
    int nStored = 0;
    int seed = 32'hf1183718;
    int cStep, rStep, t;
    wire [15:0] gap = 16'h2d8 + 16'(3 * pairCount);
    wire bothExp = sequencerControl[4] | (sequencerControl[0]
        & (sequencerControl[2:1] == 2'h1 || sequencerControl[2:1] == 2'h2));

    always #5 core_clk = ~core_clk;

    pixel_readout_addressing dut (.core_clk(core_clk), .rst_b(rst_b),
        .frameStart(frameStart), .rowAdvance(rowAdvance), .arrayControl(arrayControl),
        .sequencerControl(sequencerControl), .colOrigin(colOrigin), .rowOrigin(rowOrigin),
        .rowCount(rowCount), .pairCount(pairCount), .shutterRows(shutterRows),
        .readRow(readRow), .resetRow(resetRow), .rowSelect(rowSelect), .resetPulse(resetPulse),
        .bothSides(bothSides), .oddColumn(oddColumn), .evenColumn(evenColumn),
        .pixelValid(pixelValid), .rowBlanking(rowBlanking), .doubleSample(doubleSample),
        .frameDone(frameDone), .longSlopeRows(longSlopeRows),
        .shortSlopeRows(shortSlopeRows));

    camera_controller_model partner (.core_clk(core_clk), .startReq(startReq),
        .nRows(rowCount), .gap(gap), .frameStart(frameStart), .rowAdvance(rowAdvance),
        .busy(busy));

    // ------------------------------------------------
    // Expectation helpers and checks
    // ------------------------------------------------
    function automatic int step_of(input skip_code_t c);
        return c[2] ? 12 : 2 * (int'(c[1:0]) + 1);
    endfunction : step_of

    task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic summarize;
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic check_row(input int r);
        int cnt;
        cnt = 0;
        for (int w = 0; w < 50 && rowBlanking !== 1'b1; w++) @(negedge core_clk);
        cmp_val({11'h0, rowBlanking}, 12'h001);
        cmp_val(readRow, expRow);
        cmp_val(resetRow, expRow + shutterRows);
        cmp_val(evenColumn, colBase);
        cmp_val(longSlopeRows, rowCount);
        cmp_val(shortSlopeRows, shutterRows);
        cmp_val({11'h0, doubleSample}, {11'h0, ~sequencerControl[0]});
        cmp_val({11'h0, bothSides}, {11'h0, bothExp});
        cmp_val({11'h0, resetPulse}, {11'h0, (~sequencerControl[0] | (r == 0))});
        cmp_val({11'h0, rowSelect}, 12'h001);
        while (rowBlanking === 1'b1 && cnt < 800) begin
            @(negedge core_clk);
            cnt++;
        end
        cmp_val(12'(cnt), 12'h2d0);
        cnt = 0;
        while (pixelValid === 1'b1 && cnt < 64) begin
            // Mid-slot sampling keeps a one-cycle column lag from hiding a bad step
            if (cnt % 3 == 1) begin
                cmp_val(evenColumn, colBase + 12'(cStep * (cnt / 3)));
                cmp_val(oddColumn, colBase + 12'(cStep * (cnt / 3)) + 12'h001);
            end
            @(negedge core_clk);
            cnt++;
        end
        cmp_val(12'(cnt), 12'(3 * pairCount));
        // the bench counts every row read with double sampling off
        if (doubleSample === 1'b0) begin
            nStored++;
        end
    endtask : check_row

    // ------------------------------------------------
    // Main sequence: every skip code in both directions
    // ------------------------------------------------
    initial begin
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        for (int f = 0; f < 8; f++) begin
            @(negedge core_clk);
            arrayControl = {3'(7 - f), 3'(f), 2'($random(seed))};
            colOrigin = (f == 0) ? 7'h62 : (f == 1) ? 7'h7f : 7'($unsigned($random(seed)) % 99);
            rowOrigin = (f == 0) ? 8'h89 : (f == 1) ? 8'hff : 8'($unsigned($random(seed)) % 138);
            sequencerControl = 12'($random(seed));
            rowCount = 12'h003 + 12'(f % 2);
            pairCount = 11'h001 + 11'($unsigned($random(seed)) % 6);
            shutterRows = 12'($unsigned($random(seed)) % 200);
            colBase = 12'((colOrigin > 98 ? 98 : colOrigin) * 24);
            expRow = 12'((rowOrigin > 137 ? 137 : rowOrigin) * 24);
            cStep = step_of(arrayControl[4:2]);
            rStep = step_of(arrayControl[7:5]);
            nStored = 0;
            startReq = 1'b1;
            for (t = 0; t < 10 && frameStart !== 1'b1; t++) @(posedge core_clk);
            cmp_val({11'h0, frameStart}, 12'h001);
            @(negedge core_clk);
            startReq = 1'b0;
            @(negedge core_clk);
            cmp_val(readRow, expRow);
            for (int r = 0; r < rowCount; r++) begin
                if (r > 0) begin
                    expRow = expRow + 12'((r % 2) ? 1 : rStep - 1);
                end
                check_row(r);
            end
            for (t = 0; t < 1000 && busy !== 1'b0; t++) @(negedge core_clk);
            cmp_val({11'h0, busy}, 12'h000);
            cmp_val(12'(nStored), sequencerControl[0] ? rowCount : 12'h000);
            cmp_val({11'h0, frameDone}, 12'h001);
            cmp_val({11'h0, rowSelect}, 12'h000);
            cmp_val(readRow, expRow);
        end
        summarize();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        summarize();
    end
endmodule : pixel_readout_addressing_tb
